// [hdl/srmc_regs_top.sv]
`timescale 1ns/10ps
`default_nettype none
module srmc_regs_top (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        sclk_i,
   input  wire logic        ss_b_i,
   input  wire logic        mosi_i,
   input  wire logic        miso_sense_i,
   input  wire logic [11:0] pressure_i,
   input  wire logic [7:0]  temperature_i,
   output logic             miso_o,
   output logic             miso_oe_n_o,
   output logic             init_done_lock_o,
   output logic             miso_fault_o
);
   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [2:0]  ss_s;
      logic [1:0]  mosi_s;
      logic [1:0]  sense_s;
      logic [31:0] rx;
      logic [31:0] tx;
      logic [31:0] tx_sh;
      logic [5:0]  cnt;
      logic        bad;
      logic        mism;
      logic        miso_q;
      logic        miso_flag;
      logic        comm_flag;
      logic [7:0]  lockreg;
      logic [7:0]  otpctl;
      logic [7:0]  region;
      logic [7:0]  count;
      logic [1:0]  st;
      logic [1:0]  sf;
   } srmc_state_t;

   srmc_state_t r;
   srmc_state_t r_nxt;

   logic [srmc_pkg::NUM_CHK-1:0][7:0] chk_data;
   logic [srmc_pkg::NUM_CHK-1:0]      chk_err;
   logic [srmc_pkg::NUM_CHK-1:0]      chk_wr;
   logic        sclk_rise, sclk_fall, fstart, fend, mism_now;
   logic [1:0]  op;
   logic [7:0]  addr, wdata, rd_data;
   logic        locked, lock_viol, spi_err, wr_go, fac_err, usr_err;
   logic [1:0]  st_now, sf_now;

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins
   assign sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
   assign sclk_fall = ~r.sclk_s[1] & r.sclk_s[2];
   assign fstart    = ~r.ss_s[1] & r.ss_s[2];
   assign fend      = r.ss_s[1] & ~r.ss_s[2];
   assign mism_now  = sclk_rise & ~r.ss_s[1] & (r.cnt < srmc_pkg::FRAME_CNT)
                      & (r.sense_s[1] != r.miso_q);

   // Command decode
   assign op        = r.rx[srmc_pkg::CMD_OP_LSB +: 2];
   assign addr      = r.rx[srmc_pkg::CMD_ADDR_LSB +: 8];
   assign wdata     = r.rx[srmc_pkg::CMD_DATA_LSB +: 8];
   assign locked    = r.lockreg[srmc_pkg::LOCK_BIT];
   assign lock_viol = (op == srmc_pkg::OP_WRITE) & locked
                      & (addr != srmc_pkg::OFS_LOCK);
   assign spi_err   = r.bad | r.sclk_s[1] | (r.cnt != srmc_pkg::FRAME_CNT)
                      | (op == 2'h3) | lock_viol;
   assign wr_go     = fend & ~spi_err & (op == srmc_pkg::OP_WRITE);

   // Block integrity summaries
   assign usr_err   = |chk_err[srmc_pkg::NUM_USER-1:0];
   assign fac_err   = |chk_err[srmc_pkg::NUM_CHK-1:srmc_pkg::NUM_USER];

   ////////////////////////////////////////////////////////////////////////
   // Programmable blocks with their own checks
   genvar gi;
   generate
      for (gi = 0; gi < srmc_pkg::NUM_CHK; gi++) begin : g_chk
         assign chk_wr[gi] = wr_go & (addr == srmc_pkg::CHK_OFS[gi]);
         srmc_chk_reg #(
            .W         (8),
            .RESET_VAL (srmc_pkg::CHK_RST[gi])
         ) u_chk (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .wr_en_i   (chk_wr[gi]),
            .wr_data_i (wdata & srmc_pkg::CHK_WMASK[gi]),
            .data_o    (chk_data[gi]),
            .err_o     (chk_err[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Status now; a snapshot is taken at each frame end
   always_comb begin
      if (r.comm_flag | r.miso_flag) begin
         st_now = srmc_pkg::ST_ERROR;
         sf_now = srmc_pkg::SF_SPI;
      end else if (fac_err | usr_err) begin
         st_now = srmc_pkg::ST_ERROR;
         sf_now = srmc_pkg::SF_MEMORY;
      end else if (locked) begin
         st_now = srmc_pkg::ST_NORMAL;
         sf_now = srmc_pkg::SF_NONE;
      end else begin
         st_now = srmc_pkg::ST_INIT;
         sf_now = srmc_pkg::SF_NONE;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_data = 8'h00;
      case (addr)
         srmc_pkg::OFS_COUNT:    rd_data = r.count;
         srmc_pkg::OFS_SUMMARY: begin
            rd_data[srmc_pkg::COMM_ERR_BIT] = r.comm_flag;
            rd_data[srmc_pkg::MEMTMP_BIT]   = fac_err | usr_err;
         end
         srmc_pkg::OFS_MEMTEMP: begin
            rd_data[srmc_pkg::FOTP_ERR_BIT] = fac_err;
            rd_data[srmc_pkg::UOTP_ERR_BIT] = usr_err;
         end
         srmc_pkg::OFS_OUTCHK:
            rd_data[srmc_pkg::MISO_ERR_BIT] = r.miso_flag;
         srmc_pkg::OFS_TEMP:     rd_data = temperature_i;
         srmc_pkg::OFS_LOCK:     rd_data = r.lockreg;
         srmc_pkg::OFS_OTPCTL:   rd_data = r.otpctl;
         srmc_pkg::OFS_RGN_LOAD: rd_data = r.region;
         srmc_pkg::OFS_RGN_ACT:  rd_data = r.region;
         default: begin
            for (int i = 0; i < srmc_pkg::NUM_CHK; i++) begin
               if (addr == srmc_pkg::CHK_OFS[i]) begin
                  rd_data = chk_data[i];
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic rd_clr;
      rd_clr  = 1'b0;
      r_nxt   = r;
      // Two-stage synchronisers plus edge history
      r_nxt.sclk_s  = {r.sclk_s[1:0], sclk_i};
      r_nxt.ss_s    = {r.ss_s[1:0], ss_b_i};
      r_nxt.mosi_s  = {r.mosi_s[0], mosi_i};
      r_nxt.sense_s = {r.sense_s[0], miso_sense_i};

      // Frame start: first reply bit out, clock must idle low
      if (fstart) begin
         r_nxt.cnt    = 6'h00;
         r_nxt.bad    = r.sclk_s[1];
         r_nxt.mism   = 1'b0;
         r_nxt.miso_q = r.tx[31];
         r_nxt.tx_sh  = {r.tx[30:0], 1'b0};
      end else if (~r.ss_s[1]) begin
         if (sclk_rise) begin
            r_nxt.rx = {r.rx[30:0], r.mosi_s[1]};
            if (r.cnt != srmc_pkg::CNT_MAX) begin
               r_nxt.cnt = r.cnt + 6'h01;
            end
         end
         if (sclk_fall && r.cnt != 6'h00) begin
            r_nxt.miso_q = r.tx_sh[31];
            r_nxt.tx_sh  = {r.tx_sh[30:0], 1'b0};
         end
         if (mism_now) begin
            r_nxt.mism = 1'b1;
         end
      end

      // Frame end: act on command and build the next reply
      if (fend) begin
         r_nxt.st = st_now;
         r_nxt.sf = sf_now;
         if (spi_err | r.sclk_s[1] | r.mism) begin
            r_nxt.tx = srmc_pkg::ERR_WORD;
         end else begin
            case (op)
               srmc_pkg::OP_SENSOR: begin
                  r_nxt.tx    = {st_now, sf_now, pressure_i,
                                 temperature_i, 8'h00};
                  r_nxt.count = r.count + 8'h01;
               end
               srmc_pkg::OP_READ: begin
                  r_nxt.tx = {st_now, sf_now, addr, rd_data, 12'h000};
                  rd_clr   = 1'b1;
               end
               default:
                  r_nxt.tx = {st_now, sf_now, addr, wdata, 12'h000};
            endcase
         end
         if (spi_err | r.sclk_s[1]) begin
            r_nxt.comm_flag = 1'b1;
         end
      end

      // Write proceeds even when the data-out check failed
      if (wr_go) begin
         case (addr)
            srmc_pkg::OFS_LOCK:
               r_nxt.lockreg = (wdata & srmc_pkg::LOCK_WMASK)
                  | (r.lockreg & 8'h80);
            srmc_pkg::OFS_OTPCTL:
               r_nxt.otpctl = wdata & srmc_pkg::OTPCTL_WMASK;
            srmc_pkg::OFS_RGN_LOAD:
               r_nxt.region = wdata & srmc_pkg::RGN_WMASK;
            default: ;
         endcase
      end

      // Read-to-clear flags; a new event wins over the clear
      if (rd_clr && addr == srmc_pkg::OFS_OUTCHK) begin
         r_nxt.miso_flag = 1'b0;
      end
      if (rd_clr && addr == srmc_pkg::OFS_SUMMARY) begin
         r_nxt.comm_flag = 1'b0;
      end
      if (mism_now) begin
         r_nxt.miso_flag = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r         <= '0;
         r.sclk_s  <= 3'h0;
         r.ss_s    <= 3'h7;
         r.lockreg <= srmc_pkg::RST_LOCK;
         r.otpctl  <= srmc_pkg::RST_OTPCTL;
         r.region  <= srmc_pkg::RST_RGN;
         r.count   <= srmc_pkg::RST_COUNT;
      end else begin
         r <= r_nxt;
      end
   end

   // Outputs
   assign miso_o           = r.miso_q;
   assign miso_oe_n_o      = r.ss_s[1];
   assign init_done_lock_o = locked;
   assign miso_fault_o     = r.miso_flag;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_valid_end(logic [1:0] o);
      fend && !spi_err && !r.sclk_s[1] && op == o;
   endsequence
   sequence s_err_reply;
      r.tx == srmc_pkg::ERR_WORD;
   endsequence

   AST_MISO_FLAG_SET: assert property (mism_now |=> r.miso_flag ##1
      r.miso_flag) else $error("mismatch did not set fault flag");
   AST_SENSOR_DROP: assert property (s_valid_end(srmc_pkg::OP_SENSOR)
      ##0 r.mism |=> s_err_reply ##0 r.count == $past(r.count))
      else $error("sensor request not dropped on mismatch");
   AST_WRITE_KEPT: assert property (s_valid_end(srmc_pkg::OP_WRITE)
      ##0 r.mism |-> wr_go ##1 s_err_reply)
      else $error("write on mismatch not done or no error");
   AST_READ_SKIP: assert property (s_valid_end(srmc_pkg::OP_READ)
      ##0 r.mism |=> s_err_reply ##0 r.miso_flag)
      else $error("read on mismatch not replaced by error");
   AST_BLOCK_CHECK: assert property (fend && op == srmc_pkg::OP_READ
      && addr == srmc_pkg::OFS_MEMTEMP && !spi_err && !r.mism
      && !r.sclk_s[1] |=> r.tx[19:18] == $past({fac_err, usr_err}))
      else $error("block check bits not reported");
   AST_STATUS_SNAP: assert property (s_valid_end(srmc_pkg::OP_SENSOR)
      ##0 !r.mism |=> r.tx[31:28] == $past({st_now, sf_now})
      && r.st == r.tx[31:30]) else $error("status not snapshotted");
   AST_LOCKED_WRITE: assert property (fend && lock_viol |-> !wr_go
      ##1 s_err_reply[*2]) else $error("locked write not refused");
   AST_SPI_ERR: assert property (fend && r.cnt != srmc_pkg::FRAME_CNT
      |=> r.tx[31:28] == 4'hf ##0 r.comm_flag)
      else $error("bad frame length not flagged");
   AST_RSV_ZERO: assert property (addr == srmc_pkg::OFS_LOCK |->
      (rd_data & ~srmc_pkg::LOCK_WMASK) == 8'h00)
      else $error("reserved lock bits not zero");
endmodule : srmc_regs_top
`default_nettype wire

// [hdl/srmc_pkg.sv]
package srmc_pkg;
   // Serial frame geometry
   localparam int         FRAME_BITS    = 32;
   localparam logic [5:0] FRAME_CNT     = 6'h20;
   localparam logic [5:0] CNT_MAX       = 6'h3f;
   // Command field positions
   localparam int         CMD_OP_LSB    = 30;
   localparam int         CMD_ADDR_LSB  = 22;
   localparam int         CMD_DATA_LSB  = 14;
   // Command opcodes
   localparam logic [1:0] OP_SENSOR     = 2'h0;
   localparam logic [1:0] OP_READ       = 2'h1;
   localparam logic [1:0] OP_WRITE      = 2'h2;
   // Basic and detailed status codes
   localparam logic [1:0] ST_INIT       = 2'h0;
   localparam logic [1:0] ST_NORMAL     = 2'h1;
   localparam logic [1:0] ST_ERROR      = 2'h3;
   localparam logic [1:0] SF_NONE       = 2'h0;
   localparam logic [1:0] SF_MEMORY     = 2'h1;
   localparam logic [1:0] SF_SPI        = 2'h3;
   // Register offsets
   localparam logic [7:0] OFS_COUNT     = 8'h00;
   localparam logic [7:0] OFS_SUMMARY   = 8'h01;
   localparam logic [7:0] OFS_SUPPLY    = 8'h02;
   localparam logic [7:0] OFS_MEMTEMP   = 8'h03;
   localparam logic [7:0] OFS_OUTCHK    = 8'h04;
   localparam logic [7:0] OFS_TEMP      = 8'h0e;
   localparam logic [7:0] OFS_LOCK      = 8'h10;
   localparam logic [7:0] OFS_OTPCTL    = 8'h11;
   localparam logic [7:0] OFS_RGN_LOAD  = 8'h14;
   localparam logic [7:0] OFS_RGN_ACT   = 8'h15;
   // Field positions
   localparam int         LOCK_BIT      = 7;
   localparam int         MISO_ERR_BIT  = 7;
   localparam int         FOTP_ERR_BIT  = 7;
   localparam int         UOTP_ERR_BIT  = 6;
   localparam int         COMM_ERR_BIT  = 5;
   localparam int         MEMTMP_BIT    = 4;
   // Writable bit masks
   localparam logic [7:0] LOCK_WMASK    = 8'h8b;
   localparam logic [7:0] OTPCTL_WMASK  = 8'h8f;
   localparam logic [7:0] RGN_WMASK     = 8'hf0;
   // Reset values
   localparam logic [7:0] RST_LOCK      = 8'h00;
   localparam logic [7:0] RST_OTPCTL    = 8'h00;
   localparam logic [7:0] RST_RGN       = 8'h00;
   localparam logic [7:0] RST_COUNT     = 8'h00;
   // Checked programmable registers: six user, two factory
   localparam int         NUM_CHK       = 8;
   localparam int         NUM_USER      = 6;
   localparam logic [NUM_CHK-1:0][7:0] CHK_OFS =
      {8'h3f, 8'h3e, 8'h43, 8'h42, 8'h40, 8'h3d, 8'h1b, 8'h1a};
   localparam logic [NUM_CHK-1:0][7:0] CHK_WMASK =
      {8'hff, 8'hff, 8'h04, 8'h6c, 8'hf0, 8'h7f, 8'h8f, 8'h8f};
   // Identity value is arbitrary
   localparam logic [NUM_CHK-1:0][7:0] CHK_RST =
      {8'h00, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Whole error reply word
   localparam logic [31:0] ERR_WORD     = {ST_ERROR, SF_SPI, 28'h0};
endpackage : srmc_pkg

// [hdl/srmc_chk_reg.sv]
`timescale 1ns/10ps
`default_nettype none
module srmc_chk_reg #(
   parameter int         W         = 8,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic         wr_en_i,
   input  wire logic [W-1:0] wr_data_i,
   output logic      [W-1:0] data_o,
   output logic              err_o
);
   typedef struct packed {
      logic [W-1:0] data;
      logic         par;
   } srmc_chk_t;

   srmc_chk_t r;
   srmc_chk_t r_nxt;

   // Value plus independent parity kept on each load
   always_comb begin
      r_nxt = r;
      if (wr_en_i) begin
         r_nxt.data = wr_data_i;
         r_nxt.par  = ^wr_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{data: RESET_VAL, par: ^RESET_VAL};
      end else begin
         r <= r_nxt;
      end
   end

   // Stored parity against recomputed parity
   assign data_o = r.data;
   assign err_o  = (^r.data) != r.par;
endmodule : srmc_chk_reg
`default_nettype wire

// [tb/srmc_host.sv]
`timescale 1ns/10ps
`default_nettype none
module srmc_host (
   input  wire logic ref_clk_i,
   input  wire logic miso_i,
   input  wire logic miso_oe_n_i,
   output logic      sclk_o,
   output logic      ss_b_o,
   output logic      mosi_o,
   output logic      miso_sense_o
);
   logic last_r = 1'b0;
   logic flip_r = 1'b0;
   // Pin level: inverse of last bit once released, else driven bit
   assign miso_sense_o = miso_oe_n_i ? ~last_r : (miso_i ^ flip_r);
   // Remember the last driven level
   always @(posedge ref_clk_i) begin
      if (!miso_oe_n_i)
         last_r <= miso_i;
   end
   // Idle bus: select high, clock low
   initial begin
      sclk_o = 1'b0;
      ss_b_o = 1'b1;
      mosi_o = 1'b0;
   end
   // One frame, mode 0, MSB first; flip corrupts one pin bit
   // Fewer than 32 bits gives a cut frame
   task automatic xfer(input logic [31:0] cmd, input bit flip,
                       input int nbits, output logic [31:0] rep);
      @(negedge ref_clk_i);
      ss_b_o = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      for (int i = 31; i >= 32 - nbits; i--) begin
         mosi_o = cmd[i];
         flip_r = flip && (i == 5);
         repeat (5) @(negedge ref_clk_i);
         rep[i] = miso_i;
         sclk_o = 1'b1;
         repeat (5) @(negedge ref_clk_i);
         sclk_o = 1'b0;
      end
      flip_r = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      ss_b_o = 1'b1;
      repeat (8) @(negedge ref_clk_i);
   endtask : xfer
endmodule : srmc_host
`default_nettype wire

// [tb/sensor_regs_miso_check_test.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) \
   begin \
      total_checks++; \
      if ((got) !== (want)) begin \
         fails++; \
         $display("Error at %0t: got %h want %h", $time, got, want); \
      end \
   end
module sensor_regs_miso_check_test;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        sclk, ss_b, mosi, sense, miso, oe_n, lock, fault;
   logic [11:0] pres    = 12'h000;
   logic [7:0]  temp    = 8'h00;
   int          fails   = 0;
   int          total_checks = 0;
   logic [7:0]  mreg [256];
   logic [7:0]  wm [256];
   logic        m_lock, m_fault, m_comm;
   logic [7:0]  m_count;
   logic [31:0] exp_rep, exp_mask, rep;
   logic [7:0]  rd_list [23] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h1a, 8'h1b,
      8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'hff};
   logic [7:0]  wr_list [14] = '{8'h11, 8'h14, 8'h15, 8'h12, 8'h1a,
      8'h1b, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h42, 8'h43, 8'h02, 8'h0e};
   // Clock, 50 ns period
   always #25 ref_clk = ~ref_clk;
   srmc_regs_top DUT (
      .ref_clk_i        (ref_clk),
      .rst_i            (rst),
      .sclk_i           (sclk),
      .ss_b_i           (ss_b),
      .mosi_i           (mosi),
      .miso_sense_i     (sense),
      .pressure_i       (pres),
      .temperature_i    (temp),
      .miso_o           (miso),
      .miso_oe_n_o      (oe_n),
      .init_done_lock_o (lock),
      .miso_fault_o     (fault)
   );
   srmc_host u_host (
      .ref_clk_i    (ref_clk),
      .miso_i       (miso),
      .miso_oe_n_i  (oe_n),
      .sclk_o       (sclk),
      .ss_b_o       (ss_b),
      .mosi_o       (mosi),
      .miso_sense_o (sense)
   );
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // Model reset state and writable masks
   task automatic init_model;
      for (int i = 0; i < 256; i++) begin
         mreg[i] = 8'h00;
         wm[i] = 8'h00;
      end
      for (int i = 0; i < srmc_pkg::NUM_CHK; i++) begin
         mreg[srmc_pkg::CHK_OFS[i]] = srmc_pkg::CHK_RST[i];
         wm[srmc_pkg::CHK_OFS[i]] = srmc_pkg::CHK_WMASK[i];
      end
      wm[srmc_pkg::OFS_LOCK] = srmc_pkg::LOCK_WMASK;
      wm[srmc_pkg::OFS_OTPCTL] = srmc_pkg::OTPCTL_WMASK;
      wm[srmc_pkg::OFS_RGN_LOAD] = srmc_pkg::RGN_WMASK;
      {m_lock, m_fault, m_comm, m_count} = '0;
      exp_rep = 32'h0;
      exp_mask = 32'hffffffff;
   endtask : init_model
   // One frame: check previous reply, then predict the next one
   // Kind 0 plain, 1 corrupts one pin bit, 2 cuts the frame to 16 bits
   task automatic frame(input logic [1:0] op, input logic [7:0] a,
                        input logic [7:0] d, input int kind);
      logic [7:0] rd;
      logic       err;
      logic       flip;
      logic       cut;
      logic [3:0] stat;
      flip = (kind == 1);
      cut = (kind == 2);
      @(negedge ref_clk);
      pres = 12'($urandom);
      temp = 8'($urandom);
      u_host.xfer({op, a, d, 14'h0000}, flip, cut ? 16 : 32, rep);
      exp_mask = cut ? 32'hffff0000 : 32'hffffffff;
      `CHK(rep & exp_mask, exp_rep & exp_mask)
      rd = mreg[a];
      err = cut || (op == 2'h3);
      if (flip)
         m_fault = 1'b1;
      // Status as it stands when select rises, before this frame acts
      stat = (m_comm || m_fault) ? {srmc_pkg::ST_ERROR, srmc_pkg::SF_SPI} :
             {m_lock ? srmc_pkg::ST_NORMAL : srmc_pkg::ST_INIT, 2'b00};
      // Live read values
      case (a)
         srmc_pkg::OFS_COUNT:   rd = m_count;
         srmc_pkg::OFS_SUMMARY: rd = {2'b00, m_comm, 5'h00};
         srmc_pkg::OFS_OUTCHK:  rd = {m_fault, 7'h00};
         srmc_pkg::OFS_TEMP:    rd = temp;
         srmc_pkg::OFS_RGN_ACT: rd = mreg[srmc_pkg::OFS_RGN_LOAD];
         default: ;
      endcase
      if (op == srmc_pkg::OP_WRITE && m_lock && a != srmc_pkg::OFS_LOCK)
         err = 1'b1;
      else if (op == srmc_pkg::OP_WRITE && !err) begin
         mreg[a] = (mreg[a] & ~wm[a]) | (d & wm[a]);
         if (a == srmc_pkg::OFS_LOCK) begin
            mreg[a][7] = mreg[a][7] | m_lock;
            m_lock = mreg[a][7];
         end
      end
      // Valid reads clear their flag; skipped on a mismatch
      if (op == srmc_pkg::OP_READ && !err && !flip) begin
         if (a == srmc_pkg::OFS_SUMMARY)
            m_comm = 1'b0;
         if (a == srmc_pkg::OFS_OUTCHK)
            m_fault = 1'b0;
      end
      if (op == srmc_pkg::OP_SENSOR && !err && !flip)
         m_count++;
      if (err)
         m_comm = 1'b1;
      if (err || flip)
         exp_rep = srmc_pkg::ERR_WORD;
      else if (op == srmc_pkg::OP_SENSOR)
         exp_rep = {stat, pres, temp, 8'h00};
      else
         exp_rep = {stat, a, (op == srmc_pkg::OP_WRITE) ? d : rd, 12'h000};
      `CHK(fault, m_fault)
      `CHK(lock, m_lock)
   endtask : frame
   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #3000000;
      fails++;
      finish_test();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h9d94));
      init_model();
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      foreach (rd_list[i])
         frame(srmc_pkg::OP_READ, rd_list[i], 8'h00, 0);
      $display("Test reset_values done");
      foreach (wr_list[i]) begin
         frame(srmc_pkg::OP_WRITE, wr_list[i], 8'($urandom), 0);
         frame(srmc_pkg::OP_READ, wr_list[i], 8'h00, 0);
      end
      $display("Test masked_writes done");
      repeat (3) frame(srmc_pkg::OP_SENSOR, 8'h00, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_COUNT, 8'h00, 0);
      $display("Test sensor_data done");
      frame(2'h3, 8'h1a, 8'h55, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_SUMMARY, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_SUMMARY, 8'h00, 0);
      $display("Test bad_opcode done");
      frame(srmc_pkg::OP_SENSOR, 8'h00, 8'h00, 2);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_SUMMARY, 8'h00, 0);
      $display("Test short_frame done");
      frame(srmc_pkg::OP_SENSOR, 8'h00, 8'h00, 1);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_COUNT, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_OUTCHK, 8'h00, 0);
      frame(srmc_pkg::OP_WRITE, 8'h1a, 8'($urandom), 1);
      frame(srmc_pkg::OP_READ, 8'h1a, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_OUTCHK, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_OUTCHK, 8'h00, 1);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_OUTCHK, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_OUTCHK, 8'h00, 0);
      $display("Test output_mismatch done");
      frame(srmc_pkg::OP_WRITE, srmc_pkg::OFS_LOCK, 8'h88, 0);
      frame(srmc_pkg::OP_WRITE, 8'h1b, 8'h0f, 0);
      frame(srmc_pkg::OP_WRITE, srmc_pkg::OFS_LOCK, 8'h03, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_LOCK, 8'h00, 0);
      frame(srmc_pkg::OP_READ, srmc_pkg::OFS_SUMMARY, 8'h00, 0);
      frame(srmc_pkg::OP_READ, 8'h1b, 8'h00, 0);
      frame(srmc_pkg::OP_SENSOR, 8'h00, 8'h00, 0);
      $display("Test init_lock done");
      finish_test();
   end
endmodule : sensor_regs_miso_check_test
`default_nettype wire
